/* File: rtl/osp_pkg.sv */
// Purpose: shared constants for the otp and sector protection command block
// Assumes: 10 MHz core clock, serial link sampled by the core clock
// Notes: opcodes, status bit positions, byte counts and timings
package osp_pkg;
  localparam logic [7:0] OP_WR_EN = 8'h06;
  localparam logic [7:0] OP_RD_STAT = 8'h05;
  localparam logic [7:0] OP_OTP_PROG = 8'h42;
  localparam logic [7:0] OP_OTP_READ = 8'h4B;
  localparam logic [7:0] OP_CFG_READ = 8'h2B;
  localparam logic [7:0] OP_CFG_PROG = 8'h2F;
  localparam logic [7:0] OP_DYN_READ = 8'hE0;
  localparam logic [7:0] OP_DYN_WRITE = 8'hE1;
  localparam logic [7:0] OP_PER_READ = 8'hE2;
  localparam logic [7:0] OP_PER_PROG = 8'hE3;
  localparam logic [7:0] OP_PER_ERASE = 8'hE4;
  localparam logic [7:0] OP_ERS_SUSP = 8'h75;
  // status register 1 bit positions
  localparam int SR_BUSY_BIT = 0;
  localparam int SR_WEN_BIT = 1;
  localparam int SR_PERR_BIT = 6;
  // byte positions counted from the opcode byte (index 0)
  localparam logic [3:0] NB_INST = 4'h1;
  localparam logic [3:0] NB_OTP_HDR = 4'h4;
  localparam logic [3:0] NB_OTP_RD = 4'h5;
  localparam logic [3:0] NB_SECT_HDR = 4'h5;
  localparam logic [3:0] NB_CFG_WR = 4'h3;
  localparam logic [3:0] NB_DYN_WR = 4'h6;
  localparam logic [3:0] NB_SAT = 4'hF;
  // self-timed operation lengths
  localparam int CLK_NS = 100;
  localparam int T_PROG_NS = 2000;
  localparam int T_ERASE_NS = 20000;
  localparam int T_BYTE_NS = 500;
  localparam logic [7:0] PROG_CYC = 8'((T_PROG_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [7:0] ERASE_CYC = 8'((T_ERASE_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [7:0] BYTE_CYC = 8'((T_BYTE_NS + CLK_NS - 1) / CLK_NS);
  // storage layout
  localparam int OTP_AW = 10;
  localparam int OTP_N = 1024;
  localparam int OTP_RGN_LSB = 6;
  localparam int SECT_LSB = 16;
  localparam int SECT_N = 256;
  localparam int FIFO_W = 18;
  localparam int FIFO_D = 8;
  localparam logic [7:0] ERASED = 8'hFF;
  localparam logic [7:0] LOCKED = 8'h00;
  localparam logic [15:0] CFG_RST = 16'hFFFF;
endpackage : osp_pkg

/* File: rtl/osp_top.sv */
// Purpose: serial flash command logic for otp and sector protection
// Assumes: SCK_I slow against MCLK_I (at least 8 core clocks per period)
// Notes: one otp program takes at most 8 data bytes (buffer depth)
`timescale 1ns/1ps

module osp_fifo #(
  parameter int W = 18,
  parameter int D = 8
) (
  input wire logic clk_i, // core clock
  input wire logic rst_i, // sync reset
  input wire logic in_valid_i, // write request
  output logic in_ready_o, // room available
  input wire logic [W-1:0] in_data_i, // write word
  output logic out_valid_o, // word available
  input wire logic out_ready_i, // read request
  output logic [W-1:0] out_data_o // head word
);
  localparam int AW = $clog2(D);
  logic [W-1:0] mem [D];
  logic [AW:0] wp_r;
  logic [AW:0] rp_r;
  wire empty = wp_r == rp_r;
  wire full = (wp_r[AW] != rp_r[AW]) && (wp_r[AW-1:0] == rp_r[AW-1:0]);
  wire do_wr = in_valid_i && !full;
  wire do_rd = out_ready_i && !empty;
  assign in_ready_o = !full;
  assign out_valid_o = !empty;
  assign out_data_o = mem[rp_r[AW-1:0]];
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wp_r <= '0;
      rp_r <= '0;
    end
    else
    begin
      if (do_wr)
        wp_r <= wp_r + 1'b1;
      if (do_rd)
        rp_r <= rp_r + 1'b1;
    end
  end
  always_ff @(posedge clk_i)
  begin
    if (do_wr)
      mem[wp_r[AW-1:0]] <= in_data_i;
  end
endmodule : osp_fifo

module osp_top (
  input wire logic MCLK_I, // core clock
  input wire logic RESET_I, // sync reset, active high
  input wire logic CS_N_I, // chip select, active low
  input wire logic SCK_I, // serial clock pin
  input wire logic SI_I, // serial data in
  output logic SO_O, // serial data out
  output logic SO_OE_O, // high while driving serial out
  input wire logic [15:0] OTP_LOCK_I, // per-region otp lock, core clock
  output logic [7:0] STATUS_O, // status register 1
  output logic [15:0] CFG_REG_O, // protection config register
  output logic SUSPEND_O // accepted erase suspend pulse
);
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_DRAIN = 3'b010,
    ST_WAIT = 3'b100
  } osp_state_t;

  function automatic logic at_byte(input logic [3:0] b, input logic [2:0] k,
                                   input logic [3:0] n);
    return (b == n) && (k == 3'h0);
  endfunction : at_byte

  function automatic logic [3:0] rd_first(input logic [7:0] c);
    case (c)
      osp_pkg::OP_RD_STAT, osp_pkg::OP_CFG_READ: return osp_pkg::NB_INST;
      osp_pkg::OP_OTP_READ: return osp_pkg::NB_OTP_RD;
      osp_pkg::OP_DYN_READ, osp_pkg::OP_PER_READ:
        return osp_pkg::NB_SECT_HDR;
      default: return 4'h0;
    endcase
  endfunction : rd_first

  logic cs_s1, cs_s2, cs_q, sck_s1, sck_s2, sck_q, si_s1, si_s2;
  logic [2:0] bit_r;
  logic [3:0] byte_r;
  logic [6:0] sh_r;
  logic [7:0] cmd_r, dat_r, cfgl_r, tx_r, op_r, tmr_r;
  logic [31:0] adr_r;
  logic [9:0] wofs_r;
  logic [10:0] ob_r;
  logic so_r, oe_r, wel_r, perr_r, susp_r;
  osp_state_t st_r;
  logic [15:0] cfg_r;
  logic [7:0] otp [osp_pkg::OTP_N];
  logic [7:0] dynamic_sector_lock [osp_pkg::SECT_N];
  logic [7:0] persistent_sector_lock [osp_pkg::SECT_N];

  // third stage only feeds edge detection, never the first stage
  always_ff @(posedge MCLK_I)
  begin
    if (RESET_I)
      {cs_s1, cs_s2, cs_q, sck_s1, sck_s2, sck_q, si_s1, si_s2} <= 8'hE0;
    else
    begin
      cs_s1 <= CS_N_I;
      cs_s2 <= cs_s1;
      cs_q <= cs_s2;
      sck_s1 <= SCK_I;
      sck_s2 <= sck_s1;
      sck_q <= sck_s2;
      si_s1 <= SI_I;
      si_s2 <= si_s1;
    end
  end

  wire idle = st_r == ST_IDLE;
  wire rise = sck_s2 && !sck_q && !cs_s2;
  wire fall = !sck_s2 && sck_q && !cs_s2;
  wire cs_rise = cs_s2 && !cs_q;
  wire byte_done = rise && (bit_r == 3'h7);
  wire [7:0] in_byte = {sh_r, si_s2};
  wire have_cmd = byte_r != 4'h0;
  wire is_otp = (cmd_r == osp_pkg::OP_OTP_PROG)
             || (cmd_r == osp_pkg::OP_OTP_READ);
  wire [3:0] hdr_end = is_otp ? osp_pkg::NB_OTP_HDR : osp_pkg::NB_SECT_HDR;
  wire adr_shift = rise && have_cmd && (byte_r < hdr_end);
  wire [7:0] sect = adr_r[osp_pkg::SECT_LSB +: 8];
  wire [11:0] otp_idx = {2'b00, adr_r[9:0]} + {1'b0, ob_r};
  wire [7:0] status = {1'b0, perr_r, 4'h0, wel_r, !idle};
  // only status reads are answered while an operation runs
  wire rd_ok = idle || (cmd_r == osp_pkg::OP_RD_STAT);
  wire rd_act = have_cmd && (rd_first(cmd_r) != 4'h0)
             && (byte_r >= rd_first(cmd_r)) && rd_ok;
  wire [7:0] cfg_byte = ob_r[0] ? cfg_r[15:8] : cfg_r[7:0];
  // past the top otp address the data is undefined; all ones here
  wire [7:0] otp_byte = (otp_idx[11:10] != 2'b00) ? osp_pkg::ERASED
                      : otp[otp_idx[9:0]];
  wire [7:0] out_byte =
    (cmd_r == osp_pkg::OP_RD_STAT) ? status :
    (cmd_r == osp_pkg::OP_CFG_READ) ? cfg_byte :
    (cmd_r == osp_pkg::OP_DYN_READ) ? dynamic_sector_lock[sect] :
    (cmd_r == osp_pkg::OP_PER_READ) ? persistent_sector_lock[sect] :
    otp_byte;

  // serial receive: bit and byte counters, opcode, address, data
  always_ff @(posedge MCLK_I)
  begin
    if (RESET_I || cs_s2)
    begin
      bit_r <= 3'h0;
      byte_r <= 4'h0;
      sh_r <= 7'h00;
    end
    else if (rise)
    begin
      bit_r <= bit_r + 3'h1;
      sh_r <= in_byte[6:0];
      if (byte_done && byte_r != osp_pkg::NB_SAT)
        byte_r <= byte_r + 4'h1;
    end
  end

  always_ff @(posedge MCLK_I)
  begin
    if (RESET_I)
    begin
      cmd_r <= 8'h00;
      adr_r <= 32'h0000_0000;
      dat_r <= 8'h00;
      cfgl_r <= 8'h00;
    end
    else
    begin
      if (byte_done && !have_cmd)
        cmd_r <= in_byte;
      if (adr_shift)
        adr_r <= {adr_r[30:0], si_s2};
      if (byte_done && cmd_r == osp_pkg::OP_CFG_PROG && byte_r == 4'h1)
        cfgl_r <= in_byte;
      if (byte_done && cmd_r == osp_pkg::OP_CFG_PROG && byte_r == 4'h2)
        dat_r <= in_byte;
      if (byte_done && cmd_r == osp_pkg::OP_DYN_WRITE && byte_r == 4'h5)
        dat_r <= in_byte;
    end
  end

  // serial transmit: new bit after every falling edge, msb of byte first
  always_ff @(posedge MCLK_I)
  begin
    if (RESET_I || cs_s2)
    begin
      so_r <= 1'b0;
      oe_r <= 1'b0;
      tx_r <= 8'h00;
      ob_r <= 11'h000;
    end
    else if (fall && rd_act)
    begin
      oe_r <= 1'b1;
      if (bit_r == 3'h0)
      begin
        so_r <= out_byte[7];
        tx_r <= {out_byte[6:0], 1'b0};
        // otp reads stop counting at the top; config reads keep
        // alternating bytes however long select stays low
        if (ob_r != 11'h7FF || !is_otp)
          ob_r <= ob_r + 11'h001;
      end
      else
      begin
        so_r <= tx_r[7];
        tx_r <= {tx_r[6:0], 1'b0};
      end
    end
  end

  // otp data bytes queue up while select is low
  wire f_in_ready, f_out_valid;
  wire [17:0] f_out;
  wire push = byte_done && cmd_r == osp_pkg::OP_OTP_PROG
           && byte_r >= osp_pkg::NB_OTP_HDR && idle && wel_r;
  wire [9:0] wadr = adr_r[9:0] + wofs_r;
  wire pop_drain = (st_r == ST_DRAIN) && (tmr_r == 8'h00) && f_out_valid;
  // leftovers of a command that never ran are thrown away between frames
  wire pop = pop_drain || (idle && cs_s2 && !cs_rise);
  always_ff @(posedge MCLK_I)
  begin
    if (RESET_I || cs_s2)
      wofs_r <= 10'h000;
    else if (push && f_in_ready)
      wofs_r <= wofs_r + 10'h001;
  end

  osp_fifo #(.W(osp_pkg::FIFO_W), .D(osp_pkg::FIFO_D)) u_fifo (
    .clk_i(MCLK_I),
    .rst_i(RESET_I),
    .in_valid_i(push),
    .in_ready_o(f_in_ready),
    .in_data_i({wadr, in_byte}),
    .out_valid_o(f_out_valid),
    .out_ready_i(pop),
    .out_data_o(f_out)
  );

  // command acceptance at the rising edge of select
  wire g_otp = cmd_r == osp_pkg::OP_OTP_PROG && byte_r > osp_pkg::NB_OTP_HDR
            && bit_r == 3'h0;
  wire g_cfg = cmd_r == osp_pkg::OP_CFG_PROG
            && at_byte(byte_r, bit_r, osp_pkg::NB_CFG_WR);
  wire g_dyn = cmd_r == osp_pkg::OP_DYN_WRITE
            && at_byte(byte_r, bit_r, osp_pkg::NB_DYN_WR);
  wire g_pp = cmd_r == osp_pkg::OP_PER_PROG
           && at_byte(byte_r, bit_r, osp_pkg::NB_SECT_HDR);
  wire g_pe = cmd_r == osp_pkg::OP_PER_ERASE
           && at_byte(byte_r, bit_r, osp_pkg::NB_INST);
  wire cmd_frame = cs_rise && idle && have_cmd;
  wire go = cmd_frame && wel_r
         && (g_otp || g_cfg || g_dyn || g_pp || g_pe);
  wire write_enable_cmd = cmd_frame && cmd_r == osp_pkg::OP_WR_EN
           && at_byte(byte_r, bit_r, osp_pkg::NB_INST);
  wire susp_req = cs_rise && !idle && have_cmd
               && cmd_r == osp_pkg::OP_ERS_SUSP
               && at_byte(byte_r, bit_r, osp_pkg::NB_INST);
  wire done = (st_r == ST_WAIT && tmr_r == 8'h00)
           || (st_r == ST_DRAIN && tmr_r == 8'h00 && !f_out_valid);
  wire [3:0] rgn = f_out[8 + osp_pkg::OTP_RGN_LSB +: 4];
  wire otp_err = pop_drain && OTP_LOCK_I[rgn]
              && f_out[7:0] != osp_pkg::ERASED;

  always_ff @(posedge MCLK_I)
  begin
    if (RESET_I)
    begin
      st_r <= ST_IDLE;
      op_r <= 8'h00;
      tmr_r <= 8'h00;
    end
    else
    begin
      unique case (st_r)
        ST_IDLE:
          if (go)
          begin
            op_r <= cmd_r;
            st_r <= g_otp ? ST_DRAIN : ST_WAIT;
            tmr_r <= g_otp ? 8'h00
                   : g_pe ? osp_pkg::ERASE_CYC : osp_pkg::PROG_CYC;
          end
        ST_DRAIN:
          if (done)
            st_r <= ST_IDLE;
          else if (pop_drain)
            tmr_r <= osp_pkg::BYTE_CYC;
          else if (tmr_r != 8'h00)
            tmr_r <= tmr_r - 8'h01;
        ST_WAIT:
          if (done)
            st_r <= ST_IDLE;
          else
            tmr_r <= tmr_r - 8'h01;
      endcase
    end
  end

  // program error stays set until reset; no clear command here
  always_ff @(posedge MCLK_I)
  begin
    if (RESET_I)
    begin
      wel_r <= 1'b0;
      perr_r <= 1'b0;
      susp_r <= 1'b0;
    end
    else
    begin
      if (write_enable_cmd)
        wel_r <= 1'b1;
      else if (done)
        wel_r <= 1'b0;
      if (otp_err)
        perr_r <= 1'b1;
      susp_r <= susp_req && op_r != osp_pkg::OP_PER_ERASE;
    end
  end

  // storage starts erased at reset for lack of a backing store
  always_ff @(posedge MCLK_I)
  begin
    if (RESET_I)
      for (int i = 0; i < osp_pkg::OTP_N; i++)
        otp[i] <= osp_pkg::ERASED;
    else if (pop_drain && !otp_err)
      otp[f_out[17:8]] <= otp[f_out[17:8]] & f_out[7:0];
  end

  always_ff @(posedge MCLK_I)
  begin
    if (RESET_I)
      for (int i = 0; i < osp_pkg::SECT_N; i++)
        dynamic_sector_lock[i] <= osp_pkg::ERASED;
    else if (go && g_dyn)
      dynamic_sector_lock[sect] <= dat_r;
  end

  always_ff @(posedge MCLK_I)
  begin
    if (RESET_I || (done && op_r == osp_pkg::OP_PER_ERASE))
      for (int i = 0; i < osp_pkg::SECT_N; i++)
        persistent_sector_lock[i] <= osp_pkg::ERASED;
    else if (go && g_pp)
      persistent_sector_lock[sect] <= osp_pkg::LOCKED;
  end

  always_ff @(posedge MCLK_I)
  begin
    if (RESET_I)
      cfg_r <= osp_pkg::CFG_RST;
    else if (go && g_cfg)
      cfg_r <= cfg_r & {dat_r, cfgl_r};
  end

  assign SO_O = so_r;
  assign SO_OE_O = oe_r;
  assign STATUS_O = status;
  assign CFG_REG_O = cfg_r;
  assign SUSPEND_O = susp_r;

  default clocking cb @(posedge MCLK_I); endclocking
  default disable iff (RESET_I);

  sequence s_write_end;
    !idle ##1 idle;
  endsequence
  sequence s_frame_nowel;
    cmd_frame && !wel_r;
  endsequence

  busy_end_latch_a: assert property (s_write_end |-> !wel_r)
    else $error("write enable latch not cleared at end of operation");
  no_wel_ignore_a: assert property (s_frame_nowel |=> idle)
    else $error("write command started without write enable latch");
  cfg_exact_end_a: assert property (
    cmd_frame && cmd_r == osp_pkg::OP_CFG_PROG && !g_cfg |=> idle)
    else $error("config program ran with a wrong bit count");
  dyn_exact_end_a: assert property (
    cmd_frame && cmd_r == osp_pkg::OP_DYN_WRITE && !g_dyn |=> idle)
    else $error("dynamic write ran with a wrong bit count");
  per_exact_end_a: assert property (
    cmd_frame && cmd_r == osp_pkg::OP_PER_PROG && !g_pp |=> idle)
    else $error("persistent program ran with a wrong bit count");
  erase_run_a: assert property (
    cmd_frame && wel_r && g_pe |=> !idle [*8])
    else $error("persistent erase did not run");
  erase_nosusp_a: assert property (
    susp_req && op_r == osp_pkg::OP_PER_ERASE |=> !SUSPEND_O)
    else $error("suspend accepted during persistent erase");
  otp_lock_err_a: assert property (otp_err |=> perr_r)
    else $error("locked otp program did not flag an error");
  stat_while_busy_a: assert property (
    !idle && have_cmd && cmd_r == osp_pkg::OP_RD_STAT && fall
    |=> SO_OE_O)
    else $error("status read not answered while busy");
  dyn_write_upd_a: assert property (
    go && g_dyn |=> dynamic_sector_lock[$past(sect)] == $past(dat_r))
    else $error("dynamic sector lock not written");
endmodule : osp_top

/* File: testbench/osp_host.sv */
// Purpose: host spi controller model for the protection command block
// Assumes: mode 0 framing, sck period of 8 core clocks, sck idles low
// Notes: whole-byte frames only, msb first per byte
`timescale 1ns/1ps

module osp_host (
  input wire logic mclk_i, // core clock
  input wire logic so_i, // serial data from device
  input wire logic so_oe_i, // device drives so
  output logic cs_n_o, // chip select, active low
  output logic sck_o, // serial clock
  output logic si_o // serial data to device
);
  initial
  begin
    cs_n_o = 1'b1;
    sck_o = 1'b0;
    si_o = 1'b0;
  end

  // a bit the device does not drive comes back unknown, so a late
  // output enable cannot pass as data
  task automatic xfer(input logic [7:0] tx[$], input int nrd,
                      output logic [7:0] rx[$]);
    int i;
    int b;
    logic [7:0] d;
    logic [7:0] r;
    rx = {};
    @(negedge mclk_i);
    cs_n_o = 1'b0;
    for (i = 0; i < tx.size() + nrd; i++)
    begin
      d = (i < tx.size()) ? tx[i] : 8'h00;
      for (b = 7; b >= 0; b--)
      begin
        si_o = d[b];
        repeat (4) @(negedge mclk_i);
        sck_o = 1'b1;
        r[b] = so_oe_i ? so_i : 1'bx;
        repeat (4) @(negedge mclk_i);
        sck_o = 1'b0;
      end
      if (i >= tx.size())
        rx.push_back(r);
    end
    repeat (4) @(negedge mclk_i);
    cs_n_o = 1'b1;
    si_o = ~si_o;
    repeat (8) @(negedge mclk_i);
  endtask : xfer
endmodule : osp_host

/* File: testbench/tb_otp_and_sector_protect_cmds.sv */
// Purpose: self-checking bench for the otp and sector protection block
// Assumes: host model frames whole bytes at 800 ns per serial bit
// Notes: program error is sticky, so the locked otp case runs last
`timescale 1ns/1ps

module tb_otp_and_sector_protect_cmds;
  logic mclk = 1'b0;
  logic reset = 1'b1;
  logic cs_n;
  logic sck;
  logic si;
  logic so;
  logic so_oe;
  logic [15:0] otp_lock = 16'h0000;
  logic [7:0] status;
  logic [15:0] cfg;
  logic suspend;
  int errors = 0;
  int check_count = 0;
  int susp_cnt = 0;

  always #50 mclk = ~mclk;

  // counted on the falling core clock edge, away from the launching edge, so the pulse is seen settled
  always @(negedge mclk)
    if (suspend === 1'b1)
      susp_cnt++;

  osp_top uut (
    .MCLK_I(mclk),
    .RESET_I(reset),
    .CS_N_I(cs_n),
    .SCK_I(sck),
    .SI_I(si),
    .SO_O(so),
    .SO_OE_O(so_oe),
    .OTP_LOCK_I(otp_lock),
    .STATUS_O(status),
    .CFG_REG_O(cfg),
    .SUSPEND_O(suspend)
  );

  osp_host host (
    .mclk_i(mclk),
    .so_i(so),
    .so_oe_i(so_oe),
    .cs_n_o(cs_n),
    .sck_o(sck),
    .si_o(si)
  );

  task automatic complete_run;
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0)
    begin
      $display("verification passed");
    end
    else
    begin
      $display("verification failed");
    end
    $finish;
  endtask : complete_run

  task automatic check(input string what, input logic [15:0] exp,
                       input logic [15:0] got);
    check_count++;
    if (got !== exp)
    begin
      errors++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic send(input logic [7:0] tx[$]);
    logic [7:0] q[$];
    host.xfer(tx, 0, q);
  endtask : send

  task automatic write_enable_cmd;
    send('{8'h06});
  endtask : write_enable_cmd

  // polls over the link so status reads during busy are exercised
  task automatic wait_idle;
    int n;
    logic [7:0] q[$];
    for (n = 0; n < 40; n++)
    begin
      host.xfer('{8'h05}, 1, q);
      if (q[0][osp_pkg::SR_BUSY_BIT] === 1'b0)
        return;
    end
    errors++;
    complete_run();
  endtask : wait_idle

  task automatic read_chk(input string what, input logic [7:0] tx[$],
                          input logic [7:0] exp[$]);
    logic [7:0] q[$];
    int i;
    host.xfer(tx, exp.size(), q);
    for (i = 0; i < exp.size(); i++)
      check(what, {8'h00, exp[i]}, {8'h00, q[i]});
  endtask : read_chk

  initial
  begin
    repeat (12) @(negedge mclk);
    reset = 1'b0;
    repeat (4) @(negedge mclk);
    check("status reset", 16'h0000, {8'h00, status});
    check("cfg reset", 16'hFFFF, cfg);
    // writes with the latch clear must leave everything alone
    send('{8'hE4});
    send('{8'hE1, 8'h00, 8'h03, 8'h00, 8'h00, 8'h5A});
    check("status no latch", 16'h0000, {8'h00, status});
    read_chk("dyn untouched", '{8'hE0, 8'h00, 8'h03, 8'h00, 8'h00},
             '{8'hFF});
    write_enable_cmd();
    read_chk("latch set", '{8'h05}, '{8'h02});
    send('{8'hE1, 8'h00, 8'h03, 8'h00, 8'h00, 8'h5A});
    check("busy after write", 16'h0003, {8'h00, status});
    wait_idle();
    check("idle after write", 16'h0000, {8'h00, status});
    read_chk("dyn repeat", '{8'hE0, 8'h00, 8'h03, 8'h00, 8'h00},
             '{8'h5A, 8'h5A, 8'h5A});
    // frames closed at the wrong bit count are dropped
    write_enable_cmd();
    send('{8'hE1, 8'h00, 8'h04, 8'h00, 8'h00});
    send('{8'hE3, 8'h00, 8'h04, 8'h00, 8'h00, 8'hAA});
    check("short frames", 16'h0002, {8'h00, status});
    read_chk("dyn short", '{8'hE0, 8'h00, 8'h04, 8'h00, 8'h00},
             '{8'hFF});
    read_chk("per long", '{8'hE2, 8'h00, 8'h04, 8'h00, 8'h00},
             '{8'hFF});
    send('{8'hE3, 8'h00, 8'h04, 8'h00, 8'h00});
    check("per busy", 16'h0003, {8'h00, status});
    wait_idle();
    read_chk("per prog", '{8'hE2, 8'h00, 8'h04, 8'h00, 8'h00},
             '{8'h00, 8'h00});
    // suspend is refused for the whole erase
    write_enable_cmd();
    send('{8'hE4});
    send('{8'h75});
    check("erase busy", 16'h0001, {15'h0000, status[0]});
    wait_idle();
    check("no suspend", 16'h0000, susp_cnt[15:0]);
    check("erase done", 16'h0000, {8'h00, status});
    read_chk("per erased", '{8'hE2, 8'h00, 8'h04, 8'h00, 8'h00},
             '{8'hFF});
    // an erase frame one byte too long must not start
    write_enable_cmd();
    send('{8'hE4, 8'h00});
    check("erase long", 16'h0002, {8'h00, status});
    write_enable_cmd();
    send('{8'hE4});
    read_chk("status in erase", '{8'h05}, '{8'h03});
    wait_idle();
    write_enable_cmd();
    send('{8'h2F, 8'h34, 8'h12});
    wait_idle();
    check("cfg prog", 16'h1234, cfg);
    read_chk("cfg read", '{8'h2B},
             '{8'h34, 8'h12, 8'h34, 8'h12});
    write_enable_cmd();
    send('{8'h2F, 8'h00});
    check("cfg short", 16'h1234, cfg);
    // otp addresses keep bits 23 to 10 at zero
    write_enable_cmd();
    send('{8'h42, 8'h00, 8'h00, 8'h10, 8'hA5});
    wait_idle();
    read_chk("otp read", '{8'h4B, 8'h00, 8'h00, 8'h10, 8'h00},
             '{8'hA5, 8'hFF});
    write_enable_cmd();
    send('{8'h42, 8'h00, 8'h00, 8'h10, 8'hF0});
    wait_idle();
    read_chk("otp and", '{8'h4B, 8'h00, 8'h00, 8'h10, 8'h00},
             '{8'hA0});
    write_enable_cmd();
    send('{8'h42, 8'h00, 8'h03, 8'hFF, 8'h3C});
    wait_idle();
    read_chk("otp top", '{8'h4B, 8'h00, 8'h03, 8'hFE, 8'h00},
             '{8'hFF, 8'h3C});
    otp_lock = 16'h0001;
    write_enable_cmd();
    send('{8'h42, 8'h00, 8'h00, 8'h20, 8'hFF});
    wait_idle();
    check("ones locked", 16'h0000, {8'h00, status});
    write_enable_cmd();
    send('{8'h42, 8'h00, 8'h00, 8'h21, 8'h00});
    wait_idle();
    check("zero locked", 16'h0040, {8'h00, status});
    read_chk("locked byte", '{8'h4B, 8'h00, 8'h00, 8'h21, 8'h00},
             '{8'hFF});
    complete_run();
  end
endmodule : tb_otp_and_sector_protect_cmds
